// File: rtl/ars_pkg.sv
/*
 * Constants, types and register map of the converter result and input select block.
 * Assumes a byte-wide register view carried in the low lane of a 32-bit Avalon-MM slave.
 */
package ars_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
   localparam logic [7:0] IDX_INPUT_SEL   = 8'h7c;
   localparam int         ADDR_W          = 10;

   localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
   localparam int         REF_MSB         = 7;
   localparam int         REF_LSB         = 6;
   localparam int         LEFT_ALIGN_BIT  = 5;
   localparam int         CHAN_MSB        = 4;
   localparam int         CHAN_LSB        = 0;

   localparam logic [9:0]  RESULT_RESET   = 10'h000;
   localparam logic [9:0]  SE_MAX         = 10'h3ff;
   localparam logic [9:0]  SE_MIN         = 10'h000;
   localparam logic [9:0]  DIFF_MAX       = 10'h1ff;
   localparam logic [9:0]  DIFF_MIN       = 10'h200;
   localparam logic signed [11:0] RAW_SE_MAX   = 12'sh3ff;
   localparam logic signed [11:0] RAW_DIFF_MAX = 12'sh1ff;
   localparam logic signed [11:0] RAW_DIFF_MIN = -12'sh200;

   // Channel code boundaries
   localparam logic [4:0] CODE_BANDGAP    = 5'h1e;
   localparam logic [4:0] CODE_GROUND     = 5'h1f;

   // Input index values beyond the eight analog pins
   localparam logic [3:0] SRC_BANDGAP     = 4'h8;
   localparam logic [3:0] SRC_GROUND      = 4'h9;

   typedef enum logic [1:0] {
      REF_PIN,
      REF_SUPPLY,
      REF_INT_1V1,
      REF_INT_2V56
   } ars_ref_e;

   typedef enum logic [1:0] {
      GAIN_1X,
      GAIN_10X,
      GAIN_200X
   } ars_gain_e;
endpackage

// File: rtl/ars_chan_decode.sv
/*
 * Decoder of the five-bit channel and gain code into mux and gain controls.
 * Assumes the code given is the one applied to the analog path.
 */
`timescale 1ns/1ps
`default_nettype none
module ars_chan_decode
   import ars_pkg::*;
(
   input  wire logic [4:0]        code,
   output logic [3:0]             pos_sel,
   output logic [3:0]             neg_sel,
   output logic                   diff_mode,
   output ars_pkg::ars_gain_e     gain
);
   always_comb begin
      pos_sel   = 4'h0;
      neg_sel   = 4'h0;
      diff_mode = 1'b0;
      gain      = GAIN_1X;
      if (code[4:3] == 2'b00) begin
         pos_sel = {1'b0, code[2:0]};
      end else if (code[4:3] == 2'b01) begin
         diff_mode = 1'b1;
         neg_sel   = {2'b00, code[2], 1'b0};
         pos_sel   = {2'b00, code[2], code[0]};
         gain      = code[1] ? GAIN_200X : GAIN_10X;
      end else if (code == CODE_BANDGAP) begin
         pos_sel = SRC_BANDGAP;
      end else if (code == CODE_GROUND) begin
         pos_sel = SRC_GROUND;
      end else begin
         // unity pairs against input 1 or 2
         diff_mode = 1'b1;
         pos_sel   = {1'b0, code[2:0]};
         neg_sel   = code[3] ? 4'h2 : 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/ars_top.sv
/*
 * Result formatting, result byte registers and input selection of a 10-bit converter.
 * Assumes a conversion core that reports busy, a one-cycle done pulse and a signed raw value,
 * and an Avalon-MM master using byte addresses.
 */
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ars_top
   import ars_pkg::*;
(
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // Avalon-MM slave
   input  wire logic [ars_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   // Conversion core
   input  wire logic                     conv_busy,
   input  wire logic                     conv_done,
   input  wire logic signed [11:0]       conv_value,
   input  wire logic                     flag_clear,
   output logic                          conversion_done_flag,
   // Applied analog selection
   output ars_pkg::ars_ref_e             ref_select,
   output logic                          internal_ref_on,
   output logic [3:0]                    pos_sel,
   output logic [3:0]                    neg_sel,
   output logic                          diff_mode,
   output ars_pkg::ars_gain_e            gain
);
   logic [7:0]  input_and_reference_select;
   logic [7:0]  next_input_and_reference_select;
   logic [6:0]  applied_sel;
   logic [6:0]  next_applied_sel;
   logic [9:0]  result;
   logic [9:0]  next_result;
   logic        result_lock;
   logic        next_result_lock;
   logic        next_conversion_done_flag;
   logic        ack;
   logic        next_ack;
   logic [31:0] next_readdata;
   logic [9:0]  coded;
   logic [7:0]  result_low_byte;
   logic [7:0]  result_high_byte;
   logic [7:0]  reg_index;
   logic        word_ok;
   logic        wr_take;
   logic        rd_take;
   logic        low_rd_start;

   assign reg_index       = avs_address[ADDR_W-1:2];
   assign word_ok         = (avs_address[1:0] == 2'b00);
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_take         = avs_write & ack;
   assign rd_take         = avs_read & ack;
   assign low_rd_start    = avs_read & ~ack & word_ok & (reg_index == IDX_RESULT_LOW);

   ars_chan_decode u_decode (
      .code      (applied_sel[CHAN_MSB:CHAN_LSB]),
      .pos_sel   (pos_sel),
      .neg_sel   (neg_sel),
      .diff_mode (diff_mode),
      .gain      (gain)
   );

   // reference decode; pin mode keeps internal reference off
   assign ref_select      = ars_ref_e'(applied_sel[6:5]);
   assign internal_ref_on = applied_sel[6];

   // Raw value to 10-bit code
   always_comb begin
      coded = RESULT_RESET;
      if (diff_mode) begin
         if (conv_value > RAW_DIFF_MAX) begin
            coded = DIFF_MAX;
         end else if (conv_value < RAW_DIFF_MIN) begin
            coded = DIFF_MIN;
         end else begin
            // two's complement, sign in bit 9
            coded = conv_value[9:0];
         end
      end else begin
         if (conv_value < 12'sh000) begin
            coded = SE_MIN;
         end else if (conv_value > RAW_SE_MAX) begin
            coded = SE_MAX;
         end else begin
            coded = conv_value[9:0];
         end
      end
   end

   always_comb begin
      if (input_and_reference_select[LEFT_ALIGN_BIT]) begin
         result_high_byte = result[9:2];
         result_low_byte  = {result[1:0], 6'h00};
      end else begin
         result_high_byte = {6'h00, result[9:8]};
         result_low_byte  = result[7:0];
      end
   end

   // Register file and bus answer
   always_comb begin
      next_input_and_reference_select = input_and_reference_select;
      next_readdata                   = avs_readdata;
      next_ack                        = 1'b0;
      if ((avs_read | avs_write) & ~ack) begin
         next_ack      = 1'b1;
         next_readdata = 32'h0000_0000;
         if (avs_read & word_ok) begin
            unique case (reg_index)
               IDX_INPUT_SEL:   next_readdata = {24'h00_0000, input_and_reference_select};
               IDX_RESULT_LOW:  next_readdata = {24'h00_0000, result_low_byte};
               IDX_RESULT_HIGH: next_readdata = {24'h00_0000, result_high_byte};
               default:         next_readdata = 32'h0000_0000;
            endcase
         end
      end
      if (wr_take & word_ok & avs_byteenable[0] & (reg_index == IDX_INPUT_SEL)) begin
         next_input_and_reference_select = avs_writedata[7:0];
      end
   end

   // Applied selection, result, lock and flag
   always_comb begin
      next_applied_sel          = applied_sel;
      next_result               = result;
      next_result_lock          = result_lock;
      next_conversion_done_flag = conversion_done_flag;
      // hold reference and channel while converting
      if (~conv_busy | conv_done) begin
         next_applied_sel = {input_and_reference_select[REF_MSB:REF_LSB],
                             input_and_reference_select[CHAN_MSB:CHAN_LSB]};
      end
      // lock as the low byte is latched
      // Locking at request time keeps a late done from splitting the pair
      if (low_rd_start) begin
         next_result_lock = 1'b1;
      end else if (rd_take & word_ok & (reg_index == IDX_RESULT_HIGH)) begin
         next_result_lock = 1'b0;
      end
      // Locked result drops the new value so both bytes stay paired
      if (flag_clear) begin
         next_conversion_done_flag = 1'b0;
      end
      if (conv_done) begin
         // load result with the flag; set wins over clear
         next_conversion_done_flag = 1'b1;
         if (~result_lock & ~low_rd_start) begin
            next_result = coded;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input_and_reference_select <= INPUT_SEL_RESET;
         applied_sel                <= 7'h00;
         result                     <= RESULT_RESET;
         result_lock                <= 1'b0;
         conversion_done_flag       <= 1'b0;
         ack                        <= 1'b0;
         avs_readdata               <= 32'h0000_0000;
      end else begin
         input_and_reference_select <= next_input_and_reference_select;
         applied_sel                <= next_applied_sel;
         result                     <= next_result;
         result_lock                <= next_result_lock;
         conversion_done_flag       <= next_conversion_done_flag;
         ack                        <= next_ack;
         avs_readdata               <= next_readdata;
      end
   end
endmodule
`default_nettype wire

// File: test/ars_core_model.sv
/* Behavioural conversion core: busy for LAT cycles, then a one-cycle done.
   Assumes start pulses only while idle. */
`timescale 1ns/1ps
`default_nettype none
module ars_core_model #(parameter int LAT = 12) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               start,
   input  wire logic signed [11:0] value_in,
   output logic                    busy,
   output logic                    done,
   output logic signed [11:0]      value
);
   int cnt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy  <= 1'b0;
         done  <= 1'b0;
         value <= 12'h0;
         cnt   <= 0;
      end else begin
         done  <= 1'b0;
         // Value toggles outside done so a stale sample shows
         value <= ~value;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt  <= LAT;
         end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               busy  <= 1'b0;
               done  <= 1'b1;
               value <= value_in;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: test/ars_props.sv
/* Port checker of ars_top.
   Assumes it is bound to ars_top. */
`timescale 1ns/1ps
`default_nettype none
module ars_props
   import ars_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic [9:0]        avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              conv_busy,
   input wire logic              conv_done,
   input wire logic              flag_clear,
   input wire logic              conversion_done_flag,
   input wire ars_pkg::ars_ref_e ref_select,
   input wire logic              internal_ref_on,
   input wire logic [3:0]        pos_sel,
   input wire logic [3:0]        neg_sel,
   input wire logic              diff_mode,
   input wire ars_pkg::ars_gain_e gain
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_wait_one: assert property
      ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("late answer");
   a_flag_set: assert property
      (conv_done |=> conversion_done_flag) else $error("flag not set");
   a_flag_clear: assert property
      (flag_clear && !conv_done |=> !conversion_done_flag) else $error("flag not cleared");
   a_flag_hold: assert property
      (conversion_done_flag && !flag_clear |=> conversion_done_flag) else $error("flag lost");
   a_sel_frozen: assert property
      (conv_busy && !conv_done |=> $stable({ref_select, pos_sel, neg_sel, gain}))
      else $error("selection moved");
   a_int_ref: assert property
      (internal_ref_on == ref_select[1]) else $error("internal ref wrong");
   a_se_decode: assert property
      (!diff_mode |-> neg_sel == 4'h0 && gain == GAIN_1X) else $error("single-ended wrong");
   a_gain_pair: assert property
      (gain != GAIN_1X |-> diff_mode && !neg_sel[0] && neg_sel < 4'h3) else $error("gain pair wrong");
   a_read_upper: assert property
      (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
   a_read_unmapped: assert property
      (avs_read && !avs_waitrequest && !(avs_address inside {10'h1e0, 10'h1e4, 10'h1f0})
       |-> avs_readdata == 32'h0) else $error("unmapped read data");
endmodule
bind ars_top ars_props u_props (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .conv_busy(conv_busy), .conv_done(conv_done),
   .flag_clear(flag_clear), .conversion_done_flag(conversion_done_flag),
   .ref_select(ref_select), .internal_ref_on(internal_ref_on), .pos_sel(pos_sel),
   .neg_sel(neg_sel), .diff_mode(diff_mode), .gain(gain));
`default_nettype wire

// File: test/ars_top_test.sv
/* Self-checking bench of ars_top with a conversion core model.
   Assumes only the Avalon-MM waitrequest handshake of the design. */
`timescale 1ns/1ps
`default_nettype none
module ars_top_test;
   import ars_pkg::*;
   logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, go = 0, flag_clear = 0;
   logic [9:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, q[$];
   logic avs_waitrequest, conv_busy, conv_done, conversion_done_flag, internal_ref_on, diff_mode;
   logic signed [11:0] conv_value, mval = 0;
   logic signed [11:0] sv[6] = '{600, -1, -700, 511, -512, 1};
   logic signed [11:0] uv[4] = '{1500, -5, 1023, 0};
   ars_ref_e ref_select;
   ars_gain_e gain;
   logic [3:0] pos_sel, neg_sel;
   logic [7:0] cur = 0;
   logic [3:0] be = 4'h1;
   int fails = 0, compares = 0, seed = 90;
   always #2 clock = ~clock;
   ars_top DUT (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_busy(conv_busy),
      .conv_done(conv_done), .conv_value(conv_value), .flag_clear(flag_clear),
      .conversion_done_flag(conversion_done_flag), .ref_select(ref_select),
      .internal_ref_on(internal_ref_on), .pos_sel(pos_sel), .neg_sel(neg_sel),
      .diff_mode(diff_mode), .gain(gain));
   ars_core_model #(.LAT(12)) core (.clock(clock), .rst_n(rst_n), .start(go),
      .value_in(mval), .busy(conv_busy), .done(conv_done), .value(conv_value));
   function automatic logic [13:0] dec(logic [7:0] s);
      logic [3:0] p, n;
      logic d;
      logic [1:0] g;
      p = s[3:0]; n = 0; d = 1; g = 0;
      if (s[4:0] < 8) d = 0;
      else if (s[4:0] < 16) begin
         p = {2'b0, s[2], s[0]}; n = {2'b0, s[2], 1'b0}; g = s[1] ? 2'd2 : 2'd1;
      end else if (s[4:0] < 24) n = 1;
      else if (s[4:0] < 30) begin p = s[3:0] - 4'd8; n = 2; end
      else begin p = s[3:0] - 4'd6; d = 0; end
      return {s[7:6], s[7], p, n, d, g};
   endfunction
   function automatic logic [31:0] eb(logic signed [11:0] v, logic [7:0] s, logic hi);
      logic [9:0] r;
      logic [13:0] x;
      x = dec(s);
      if (x[2]) r = v > 511 ? 10'h1ff : v < -512 ? 10'h200 : v[9:0];
      else r = v > 1023 ? 10'h3ff : v < 0 ? 10'h0 : v[9:0];
      if (s[5]) return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h0};
      return hi ? {30'h0, r[9:8]} : {24'h0, r[7:0]};
   endfunction
   task automatic cmp(logic [31:0] g, logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(logic w, logic [9:0] a, logic [7:0] d);
      @(posedge clock);
      avs_address <= a; avs_read <= !w; avs_write <= w; avs_writedata <= {24'h0, d};
      // Held until waitrequest is sampled low at a rising edge; only the watchdog ends a hang
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_read <= 0; avs_write <= 0;
   endtask
   task automatic rd(logic [9:0] a, logic [31:0] e);
      q.push_back(e);
      bus(0, a, 0);
   endtask
   task automatic wr(logic [7:0] d);
      bus(1, 10'h1f0, d);
      cur = d;
   endtask
   task automatic sel_chk(logic [7:0] s);
      repeat (2) @(posedge clock);
      @(negedge clock);
      cmp({18'h0, ref_select, internal_ref_on, pos_sel, neg_sel, diff_mode, gain}, dec(s));
   endtask
   task automatic go_c(logic signed [11:0] v);
      @(posedge clock); mval <= v; go <= 1;
      @(posedge clock); go <= 0;
   endtask
   task automatic fin;
      while (conv_done !== 1'b1) @(negedge clock);
      @(negedge clock);
      cmp(conversion_done_flag, 1);
      @(posedge clock); flag_clear <= 1;
      @(posedge clock); flag_clear <= 0;
   endtask
   task automatic cr(logic signed [11:0] v);
      go_c(v);
      fin;
      rd(10'h1e0, eb(v, cur, 0));
      rd(10'h1e4, eb(v, cur, 1));
   endtask
   task results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clock)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata, q.pop_front());
   initial begin #40000; fails++; results; end
   initial begin
      logic [7:0] s;
      repeat (8) @(posedge clock);
      rst_n <= 1;
      rd(10'h1f0, 0);
      rd(10'h1e8, 0);
      rd(10'h1e4, 0);
      wr(8'hed);
      rd(10'h1f0, 32'hed);
      rd(10'h1f2, 0);
      // Write with the low lane disabled must be ignored
      be <= 4'h0;
      bus(1, 10'h1f0, 8'h55);
      be <= 4'h1;
      rd(10'h1f0, 32'hed);
      sel_chk(8'hed);
      cr(-400);
      wr(8'h0d);
      rd(10'h1e0, 32'h70);
      rd(10'h1e4, 32'h02);
      foreach (sv[i]) cr(sv[i]);
      wr(8'h40);
      foreach (uv[i]) cr(uv[i]);
      repeat (4) cr(12'($random(seed) & 32'h3ff));
      go_c(100);
      wr(8'h1e);
      sel_chk(8'h40);
      fin;
      sel_chk(8'h1e);
      wr(8'h00);
      go_c(700);
      fin;
      rd(10'h1e0, 32'hbc);
      go_c(300);
      fin;
      rd(10'h1e4, 32'h02);
      rd(10'h1e0, 32'hbc);
      rd(10'h1e4, 32'h02);
      cr(500);
      for (int c = 0; c < 32; c++) begin
         // gain codes keep the 2.56V reference
         s = {(c > 7 && c < 16) ? 2'b11 : 2'(c), 1'b0, 5'(c)};
         wr(s);
         sel_chk(s);
      end
      results;
   end
endmodule
`default_nettype wire
